// ### src/ssc_defines.vh
// constants for the sequencer step 13 configuration block
// Overview of operation
// - bit 15 of the step register enables the step, 0 disabled and 1 enabled.
// - gain field 14:13 decodes 00 to gain 1, 01 to gain 2, and 10 or 11 to gain 4.
// - bit 4 selects the negative input, 0 analog ground and 1 external input 7.
// - positive select codes 0000 to 0111 pick external inputs 0 to 7 in order.
// - upper positive codes route internal sources (test dac, supply/4, power monitors) with automatic negative input.
// - the negative select bit is ignored whenever the positive code picks the negative input automatically.
// - the register resets to 000d: disabled, gain 1, negative automatic (bit 4 is 0 but ignored), positive code 1101.
// - positive code 1000 is temperature sensor a and 1001 an internal short to ground, both with automatic negative.
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
`define SSC_REG_INDEX 8'h9d
`define SSC_REG_ADDR 10'h274
`define SSC_RESET_VAL 16'h000d
`define SSC_WR_MASK 16'he01f
`define SSC_EN_BIT 15
`define SSC_GAIN_HI 14
`define SSC_GAIN_LO 13
`define SSC_NEG_BIT 4
`define SSC_POS_HI 3
`define SSC_POS_LO 0
`define SSC_GAIN_X1 3'h1
`define SSC_GAIN_X2 3'h2
`define SSC_GAIN_X4 3'h4
`define SSC_NEG_SRC_GND 2'h0
`define SSC_NEG_SRC_IN7 2'h1
`define SSC_NEG_SRC_AUTO 2'h2
`define SSC_POS_EXT_MAX 4'h7
`define SSC_POS_TEMP 4'h8
`define SSC_POS_SHORT 4'h9
`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2
`endif

// ### src/ssc_mux_decode.v
// decode of the step fields into converter mux and gain controls
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.vh"
module ssc_mux_decode (
    input wire [15:0] cfg_i,
    output reg step_enable_o,
    output reg [2:0] gain_o,
    output reg [15:0] pos_onehot_o,
    output reg [1:0] neg_src_o
);
    wire [3:0] pos_code;
    wire [1:0] gain_code;
    integer k;
    assign pos_code = cfg_i[`SSC_POS_HI:`SSC_POS_LO];
    assign gain_code = cfg_i[`SSC_GAIN_HI:`SSC_GAIN_LO];
    // one-hot select keeps the mux switch drive glitch free
    always @*
    begin
        step_enable_o = cfg_i[`SSC_EN_BIT];
        case (gain_code)
            2'h0: gain_o = `SSC_GAIN_X1;
            2'h1: gain_o = `SSC_GAIN_X2;
            default: gain_o = `SSC_GAIN_X4;
        endcase
        pos_onehot_o = 16'h0000;
        for (k = 0; k < 16; k = k + 1)
        begin
            // 0..7 external inputs, 8 temp, 9 short, 10..15 internal sources
            if (pos_code == k[3:0])
                pos_onehot_o[k] = 1'b1;
        end
        if (pos_code > `SSC_POS_EXT_MAX)
            neg_src_o = `SSC_NEG_SRC_AUTO;
        else if (cfg_i[`SSC_NEG_BIT])
            neg_src_o = `SSC_NEG_SRC_IN7;
        else
            neg_src_o = `SSC_NEG_SRC_GND;
    end
endmodule // ssc_mux_decode
`default_nettype wire

// ### src/ssc_step_skip.v
// per-step conversion start or skip decision for the sequencer
`timescale 1ns/1ps
`default_nettype none
module ssc_step_skip (
    input wire step_enable_i,
    input wire step_arrive_i,
    output wire start_conv_o,
    output wire skip_step_o
);
    // a disabled step passes straight on, no conversion is started
    assign start_conv_o = step_arrive_i & step_enable_i;
    assign skip_step_o = step_arrive_i & ~step_enable_i;
endmodule // ssc_step_skip
`default_nettype wire

// ### src/ssc_top.v
// sequencer step 13 configuration register with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "ssc_defines.vh"
module ssc_top (
    input wire core_clk_i,
    input wire resetn_i,
    input wire [31:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [31:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire step_arrive_i,
    output reg step_enable_o,
    output reg [2:0] gain_o,
    output reg [15:0] pos_onehot_o,
    output reg [1:0] neg_src_o,
    output reg start_conv_o,
    output reg skip_step_o
);
    reg [15:0] cfg_r;
    reg aw_held_r;
    reg w_held_r;
    reg [31:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    wire dec_en;
    wire [2:0] dec_gain;
    wire [15:0] dec_pos;
    wire [1:0] dec_neg;
    wire sk_start;
    wire sk_skip;
    wire aw_fire;
    wire w_fire;
    wire do_write;
    wire wr_hit;
    wire rd_hit;
    wire [15:0] merged;
    assign aw_fire = s_axi_awvalid_i & s_axi_awready_o;
    assign w_fire = s_axi_wvalid_i & s_axi_wready_o;
    // write commits once both address and data are held and no response is pending
    assign do_write = aw_held_r & w_held_r & ~s_axi_bvalid_o;
    // word index compare; the two low byte-address bits are ignored for aligned words
    assign wr_hit = (awaddr_r[11:2] == {2'b00, `SSC_REG_INDEX});
    assign rd_hit = (s_axi_araddr_i[11:2] == {2'b00, `SSC_REG_INDEX}) && (s_axi_araddr_i[31:12] == 20'h00000);
    // only the low two byte lanes reach the 16-bit register; reserved bits stay zero
    assign merged = {(wstrb_r[1] ? wdata_r[15:8] : cfg_r[15:8]),
                     (wstrb_r[0] ? wdata_r[7:0] : cfg_r[7:0])} & `SSC_WR_MASK;
    ssc_mux_decode u_dec (
        .cfg_i(cfg_r),
        .step_enable_o(dec_en),
        .gain_o(dec_gain),
        .pos_onehot_o(dec_pos),
        .neg_src_o(dec_neg)
    );
    ssc_step_skip u_skip (
        .step_enable_i(cfg_r[`SSC_EN_BIT]),
        .step_arrive_i(step_arrive_i),
        .start_conv_o(sk_start),
        .skip_step_o(sk_skip)
    );
    // write channels: address and data accepted in either order
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 32'h00000000;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `SSC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready_o <= ~aw_held_r & ~aw_fire & ~s_axi_bvalid_o;
            s_axi_wready_o <= ~w_held_r & ~w_fire & ~s_axi_bvalid_o;
            if (aw_fire)
            begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (w_fire)
            begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_awready_o <= 1'b0;
                s_axi_wready_o <= 1'b0;
                // unmapped addresses answer slverr and change nothing
                s_axi_bresp_o <= (wr_hit && awaddr_r[31:12] == 20'h00000) ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
            end
            else if (s_axi_bvalid_o && s_axi_bready_i)
                s_axi_bvalid_o <= 1'b0;
        end
    end
    // the configuration register itself
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
            cfg_r <= `SSC_RESET_VAL;
        else if (do_write && wr_hit && awaddr_r[31:12] == 20'h00000)
            cfg_r <= merged;
    end
    // read channel: one read at a time, data one cycle after the address
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h00000000;
            s_axi_rresp_o <= `SSC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready_o <= ~s_axi_rvalid_o & ~(s_axi_arvalid_i & s_axi_arready_o);
            if (s_axi_arvalid_i && s_axi_arready_o)
            begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_hit ? {16'h0000, cfg_r} : 32'h00000000;
                s_axi_rresp_o <= rd_hit ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
            end
            else if (s_axi_rvalid_o && s_axi_rready_i)
                s_axi_rvalid_o <= 1'b0;
        end
    end
    // registered controls toward the converter; one cycle behind the register
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            step_enable_o <= 1'b0;
            gain_o <= `SSC_GAIN_X1;
            pos_onehot_o <= 16'h2000;
            neg_src_o <= `SSC_NEG_SRC_AUTO;
            start_conv_o <= 1'b0;
            skip_step_o <= 1'b0;
        end
        else
        begin
            step_enable_o <= dec_en;
            gain_o <= dec_gain;
            pos_onehot_o <= dec_pos;
            neg_src_o <= dec_neg;
            start_conv_o <= sk_start;
            skip_step_o <= sk_skip;
        end
    end
endmodule // ssc_top
`default_nettype wire

// ### tb/ssc_props.sv
// assertion checker for the step configuration block
`timescale 1ns/1ps
`default_nettype none
module ssc_props (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic step_arrive_i,
    input wire logic step_enable_o,
    input wire logic start_conv_o,
    input wire logic skip_step_o,
    input wire logic s_axi_rvalid_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [2:0] gain_o,
    input wire logic [1:0] neg_src_o,
    input wire logic [15:0] pos_onehot_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    // a fresh okay read shows the stored word, so the decoded outputs must agree with it
    sequence okrd;
        $rose(s_axi_rvalid_o) && s_axi_rresp_o == 2'h0;
    endsequence
    // reads and decode run from the same register; a stale decode shows up here
    a_enable_follow: assert property (okrd |-> step_enable_o == s_axi_rdata_o[15]) else $error("enable mismatch");
    a_gain_decode: assert property (okrd |-> gain_o == (s_axi_rdata_o[14] ? 3'h4 : s_axi_rdata_o[13] ? 3'h2 : 3'h1)) else $error("gain bad");
    a_neg_select: assert property (okrd |-> neg_src_o == (s_axi_rdata_o[3] ? 2'h2 : {1'b0, s_axi_rdata_o[4]})) else $error("neg bad");
    a_pos_onehot: assert property (okrd |-> pos_onehot_o == (16'h1 << s_axi_rdata_o[3:0])) else $error("pos bad");
    a_reset_value: assert property ($rose(resetn_i) |-> {step_enable_o, gain_o, neg_src_o, pos_onehot_o} == {1'b0, 3'h1, 2'h2, 16'h2000}) else $error("reset bad");
    a_start_enabled: assert property (start_conv_o |-> step_enable_o && !skip_step_o) else $error("start while disabled");
    a_skip_disabled: assert property (skip_step_o |-> !step_enable_o) else $error("skip while enabled");
    a_step_answer: assert property ($past(resetn_i) |-> (start_conv_o || skip_step_o) == $past(step_arrive_i)) else $error("step answer bad");
endmodule // ssc_props
bind ssc_top ssc_props u_props (.*);
`default_nettype wire

// ### tb/ssc_top_tb.sv
// self-checking bench for the step configuration register
`timescale 1ns/1ps
`default_nettype none
module ssc_top_tb;
    logic core_clk_i = 1'b0, resetn_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0, step_arrive_i = 1'b0;
    logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0, s_axi_araddr_i = 32'h0;
    logic [3:0] s_axi_wstrb_i = 4'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic step_enable_o, start_conv_o, skip_step_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, neg_src_o;
    logic [31:0] s_axi_rdata_o, d;
    logic [2:0] gain_o;
    logic [15:0] pos_onehot_o;
    logic [3:0] c;
    int num_errors = 0, total_checks = 0;
    ssc_top dut (.*);
    // 250 mhz core clock
    always #2 core_clk_i = ~core_clk_i;
    task automatic end_sim(input int to);
        num_errors += to;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    // write: both channels offered together, each dropped once taken
    task automatic wt(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= v;
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (n > 50) end_sim(1);
        end
        while (s_axi_bvalid_o !== 1'b1);
        s_axi_bready_i <= 1'b0;
        chk(s_axi_bresp_o, er);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (n > 50) end_sim(1);
        end
        while (s_axi_rvalid_o !== 1'b1);
        s_axi_rready_i <= 1'b0;
        chk(s_axi_rdata_o, e);
        chk(s_axi_rresp_o, er);
    endtask
    // main sequence: reset, every field code, lane strobes, unmapped places
    initial
    begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        @(posedge core_clk_i);
        chk({step_enable_o, gain_o, neg_src_o, pos_onehot_o}, {1'b0, 3'h1, 2'h2, 16'h2000});
        rd(32'h274, 32'h000d, 2'h0);
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:0];
            d = {16'h0, c[0], c[1:0], 8'hff, c[1], c};
            wt(32'h274, d, 4'hf, 2'h0);
            rd(32'h274, d & 32'he01f, 2'h0);
            chk({gain_o, neg_src_o, pos_onehot_o}, {c[1] ? 3'h4 : c[0] ? 3'h2 : 3'h1, c[3] ? 2'h2 : {1'b0, c[1]}, 16'h1 << c});
            chk(step_enable_o, c[0]);
            step_arrive_i <= 1'b1;
            @(posedge core_clk_i);
            step_arrive_i <= 1'b0;
            @(posedge core_clk_i);
            chk({start_conv_o, skip_step_o}, {c[0], ~c[0]});
        end
        // only the upper lane is strobed, so the low byte must survive
        wt(32'h274, 32'h8000, 4'h2, 2'h0);
        rd(32'h274, 32'h801f, 2'h0);
        wt(32'h278, 32'h0, 4'hf, 2'h2);
        wt(32'h1274, 32'h0, 4'hf, 2'h2);
        rd(32'h278, 32'h0, 2'h2);
        rd(32'h274, 32'h801f, 2'h0);
        end_sim(0);
    end
endmodule // ssc_top_tb
`default_nettype wire
